// ==== hw/usb_ctl_pkg.sv ====
// Purpose: Shared constants for the endpoint control and descriptor RAM slice
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Register indices are word indices; byte address is four times the index
package usb_ctl_pkg;
	// ==========================================================
	// Sizes
	localparam int NUM_EP        = 16;
	localparam int ADDR_W        = 14;
	localparam int RAM_BYTES     = 256;
	localparam int RAM_AW        = 8;
	localparam int FRAME_W       = 11;
	localparam int NUM_DESC      = 64;
	localparam int DESC_BYTES    = 4;
	localparam int MIN_TABLE     = 8;
	// ==========================================================
	// Register word indices
	localparam logic [11:0] IDX_EP_CTRL  = 12'h000;
	localparam logic [11:0] IDX_DEV_ADDR = 12'h010;
	localparam logic [11:0] IDX_FRM_LOW  = 12'h011;
	localparam logic [11:0] IDX_FRM_HIGH = 12'h012;
	localparam logic [11:0] IDX_RAM_LO   = 12'h400;
	localparam logic [11:0] IDX_RAM_HI   = 12'h4FF;
	// ==========================================================
	// Endpoint control fields
	localparam int EP_HSHK   = 4;
	localparam int EP_CONDIS = 3;
	localparam int EP_OUTEN  = 2;
	localparam int EP_INEN   = 1;
	localparam int EP_STALL  = 0;
	localparam int EP_W      = 5;
	localparam logic [EP_W-1:0] EP_CTRL_RST  = 5'h00;
	localparam logic [6:0]      DEV_ADDR_RST = 7'h00;
	localparam logic [FRAME_W-1:0] FRAME_RST = 11'h000;
	// ==========================================================
	// Token kinds seen by the engine
	typedef enum logic [1:0]
	{
		TOK_OUT   = 2'h0,
		TOK_IN    = 2'h1,
		TOK_SETUP = 2'h3
	} token_kind_e;
endpackage

// ==== hw/usb_dual_ram.sv ====
// Purpose: Byte-wide dual-port RAM shared by core and engine
// Assumes: Both ports on one clock, registered read data
// Notes: No reset on the array; contents are undefined after power-up
`timescale 1ns/1ps
module usb_dual_ram
#(
	parameter int DEPTH = 256,
	parameter int AW    = 8
)
(
	input  wire logic          pclk,
	input  wire logic          a_en,
	input  wire logic          a_we,
	input  wire logic [AW-1:0] a_addr,
	input  wire logic [7:0]    a_wdata,
	output logic      [7:0]    a_rdata,
	input  wire logic          b_en,
	input  wire logic          b_we,
	input  wire logic [AW-1:0] b_addr,
	input  wire logic [7:0]    b_wdata,
	output logic      [7:0]    b_rdata
);
	// ==========================================================
	// Storage
	// Same-byte writes in one cycle: port b wins, undefined by contract
	logic [7:0] mem [DEPTH];

	always_ff @(posedge pclk)
	begin
		if (a_en && a_we)
			mem[a_addr] <= a_wdata;
		if (b_en && b_we)
			mem[b_addr] <= b_wdata;
	end

	always_ff @(posedge pclk)
	begin
		if (a_en)
			a_rdata <= mem[a_addr];
	end

	always_ff @(posedge pclk)
	begin
		if (b_en)
			b_rdata <= mem[b_addr];
	end
endmodule // usb_dual_ram

// ==== hw/usb_ep_ctrl.sv ====
// Purpose: Endpoint control, address, frame number and descriptor RAM slice
// Assumes: Engine logic shares pclk; core reaches everything over APB
// Notes: APB answers with one wait state; RAM has no reset
`timescale 1ns/1ps
module usb_ep_ctrl
	import usb_ctl_pkg::*;
(
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [usb_ctl_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                   pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          bus_reset_flag,
	input  wire logic                          sof_valid,
	input  wire logic [usb_ctl_pkg::FRAME_W-1:0] sof_frame,
	input  wire logic                          stall_issued,
	input  wire logic [3:0]                    stall_ep,
	input  wire logic                          token_valid,
	input  wire usb_ctl_pkg::token_kind_e      token_kind,
	input  wire logic [6:0]                    token_addr,
	input  wire logic [3:0]                    token_ep,
	output logic                               token_done,
	output logic                               token_accept,
	output logic                               token_handshake,
	output logic      [usb_ctl_pkg::NUM_EP-1:0] desc_live,
	input  wire logic                          eng_ram_en,
	input  wire logic                          eng_ram_we,
	input  wire logic [usb_ctl_pkg::RAM_AW-1:0] eng_ram_addr,
	input  wire logic [7:0]                    eng_ram_wdata,
	output logic      [7:0]                    eng_ram_rdata
);
	import usb_ctl_pkg::*;

	// ==========================================================
	// Address decode helpers
	function automatic logic [11:0] word_idx(input logic [ADDR_W-1:0] a);
		word_idx = a[ADDR_W-1:2];
	endfunction

	function automatic logic is_ram(input logic [ADDR_W-1:0] a);
		is_ram = (word_idx(a) >= IDX_RAM_LO) && (word_idx(a) <= IDX_RAM_HI);
	endfunction

	function automatic logic is_ep(input logic [ADDR_W-1:0] a);
		is_ep = word_idx(a) < (IDX_EP_CTRL + 12'(NUM_EP));
	endfunction

	function automatic logic is_dev_addr(input logic [ADDR_W-1:0] a);
		is_dev_addr = word_idx(a) == IDX_DEV_ADDR;
	endfunction

	function automatic logic is_frm_low(input logic [ADDR_W-1:0] a);
		is_frm_low = word_idx(a) == IDX_FRM_LOW;
	endfunction

	function automatic logic is_frm_high(input logic [ADDR_W-1:0] a);
		is_frm_high = word_idx(a) == IDX_FRM_HIGH;
	endfunction

	// ==========================================================
	// Bus handshake
	logic                   setup_ph;
	logic                   access_ph;
	logic                   done;
	logic                   wr_done;
	logic [11:0]            idx;
	logic [3:0]             ep_sel;
	logic [RAM_AW-1:0]      ram_off;
	logic                   core_ram_rd;
	logic                   core_ram_wr;
	logic                   core_ram_en;
	logic                   core_ram_we;
	logic [7:0]             core_rdata;
	logic                   pready_reg;
	logic                   pslverr_reg;
	logic [31:0]            prdata_reg;
	logic [31:0]            rd_next;
	logic                   err_next;

	assign setup_ph  = psel && !penable;
	assign access_ph = psel && penable;
	assign done      = access_ph && pready_reg;
	assign wr_done   = done && pwrite && pstrb[0];
	assign idx       = word_idx(paddr);
	assign ep_sel    = idx[3:0];
	assign ram_off   = idx[RAM_AW-1:0];

	// Read issued in setup so the byte is ready for the access phase
	assign core_ram_rd = setup_ph && !pwrite && is_ram(paddr);
	assign core_ram_wr = wr_done && is_ram(paddr);
	assign core_ram_en = core_ram_rd || core_ram_wr;
	assign core_ram_we = core_ram_wr;

	// One wait state keeps prdata and pready straight from flip-flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready_reg <= 1'b0;
		else
			pready_reg <= access_ph && !pready_reg;
	end

	// ==========================================================
	// Endpoint control registers
	logic [EP_W-1:0] ep_ctrl_reg [NUM_EP];

	genvar g;
	generate
		for (g = 0; g < NUM_EP; g++)
		begin : g_ep
			logic hit;
			logic stall_hit;
			assign hit       = wr_done && is_ep(paddr) && (ep_sel == 4'(g));
			assign stall_hit = stall_issued && (stall_ep == 4'(g));

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					ep_ctrl_reg[g][EP_W-1:1] <= EP_CTRL_RST[EP_W-1:1];
				else if (hit)
					ep_ctrl_reg[g][EP_W-1:1] <= pwdata[EP_W-1:1];
			end

			// Engine set beats a firmware clear in the same cycle
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					ep_ctrl_reg[g][EP_STALL] <= EP_CTRL_RST[EP_STALL];
				else if (stall_hit)
					ep_ctrl_reg[g][EP_STALL] <= 1'b1;
				else if (hit)
					ep_ctrl_reg[g][EP_STALL] <= pwdata[EP_STALL];
			end

			// Descriptor bytes only count once input is enabled
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					desc_live[g] <= 1'b0;
				else
					desc_live[g] <= ep_ctrl_reg[g][EP_INEN];
			end
		end
	endgenerate

	// ==========================================================
	// Device address
	logic [6:0] dev_addr_reg;
	logic       dev_wr;

	assign dev_wr = wr_done && is_dev_addr(paddr);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dev_addr_reg <= DEV_ADDR_RST;
		else if (bus_reset_flag)
			dev_addr_reg <= DEV_ADDR_RST;
		else if (dev_wr)
			dev_addr_reg <= pwdata[6:0];
	end

	// ==========================================================
	// Frame number
	logic [7:0]         frame_low_reg;
	logic [FRAME_W-9:0] frame_high_reg;

	// No core write path: the pair is read-only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			frame_low_reg <= FRAME_RST[7:0];
		else if (sof_valid)
			frame_low_reg <= sof_frame[7:0];
	end

	// Loaded on the same edge as the low byte
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			frame_high_reg <= FRAME_RST[FRAME_W-1:8];
		else if (sof_valid)
			frame_high_reg <= sof_frame[FRAME_W-1:8];
	end

	// ==========================================================
	// Token screening
	logic [EP_W-1:0] tok_ctrl;
	logic            tok_hshk;
	logic            tok_condis;
	logic            tok_outen;
	logic            tok_inen;
	logic            tok_match;
	logic            tok_ok;

	assign tok_ctrl   = ep_ctrl_reg[token_ep];
	assign tok_hshk   = tok_ctrl[EP_HSHK];
	assign tok_condis = tok_ctrl[EP_CONDIS];
	assign tok_outen  = tok_ctrl[EP_OUTEN];
	assign tok_inen   = tok_ctrl[EP_INEN];
	assign tok_match  = token_valid && (token_addr == dev_addr_reg);

	always_comb
	begin
		tok_ok = 1'b0;
		case (token_kind)
			TOK_OUT:
				tok_ok = tok_outen;
			TOK_IN:
				tok_ok = tok_inen;
			TOK_SETUP:
				tok_ok = tok_outen && tok_inen && !tok_condis;
			default:
				tok_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			token_done      <= 1'b0;
			token_accept    <= 1'b0;
			token_handshake <= 1'b0;
		end
		else
		begin
			token_done      <= token_valid;
			token_accept    <= tok_match && tok_ok;
			token_handshake <= tok_match && tok_ok && tok_hshk;
		end
	end

	// ==========================================================
	// Shared RAM, no reset on contents
	usb_dual_ram
	#(
		.DEPTH (RAM_BYTES),
		.AW    (RAM_AW)
	)
	u_ram
	(
		.pclk    (pclk),
		.a_en    (core_ram_en),
		.a_we    (core_ram_we),
		.a_addr  (ram_off),
		.a_wdata (pwdata[7:0]),
		.a_rdata (core_rdata),
		.b_en    (eng_ram_en),
		.b_we    (eng_ram_we),
		.b_addr  (eng_ram_addr),
		.b_wdata (eng_ram_wdata),
		.b_rdata (eng_ram_rdata)
	);

	// ==========================================================
	// Read mux and error answer
	always_comb
	begin
		rd_next  = 32'h0000_0000;
		err_next = 1'b0;
		if (is_ram(paddr))
			rd_next = {24'h00_0000, core_rdata};
		else if (is_ep(paddr))
			rd_next = {27'h000_0000, ep_ctrl_reg[ep_sel]};
		else if (is_dev_addr(paddr))
			rd_next = {25'h000_0000, dev_addr_reg};
		else if (is_frm_low(paddr))
			rd_next = {24'h00_0000, frame_low_reg};
		else if (is_frm_high(paddr))
			rd_next = {29'h0000_0000, frame_high_reg};
		else
			err_next = 1'b1;
	end

	// Captured on the first access edge, shown with pready
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
		else if (access_ph && !pready_reg)
		begin
			prdata_reg  <= pwrite ? 32'h0000_0000 : rd_next;
			pslverr_reg <= err_next;
		end
		else
		begin
			pslverr_reg <= 1'b0;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;
endmodule // usb_ep_ctrl

// ==== tb/usb_ep_ctrl_asserts.sv ====
// Purpose: Port checks for the endpoint control slice
// Assumes: One clock, async active-low reset
// Notes: Bound to every usb_ep_ctrl instance
`timescale 1ns/1ps
module usb_ep_ctrl_asserts
(
	input wire logic                            pclk,
	input wire logic                            presetn,
	input wire logic                            psel,
	input wire logic                            penable,
	input wire logic                            pwrite,
	input wire logic [usb_ctl_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                     prdata,
	input wire logic                            pready,
	input wire logic                            pslverr,
	input wire logic                            token_valid,
	input wire logic                            token_done,
	input wire logic                            token_accept,
	input wire logic                            token_handshake
);
	import usb_ctl_pkg::*;
	// ==========================================================
	// Sequences
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_acc_first;
		psel && penable && !$past(penable);
	endsequence
	sequence s_one_wait;
		!pready ##1 pready;
	endsequence
	// ==========================================================
	// Checks
	chk_ready_wait: assert property (s_acc_first |-> s_one_wait)
		else $error("pready not on second access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_setup_quiet: assert property (psel && !penable |-> !pready)
		else $error("pready in setup cycle");
	chk_unmapped_err: assert property (pready && paddr[13:2] inside {[12'h013:12'h3FF],
		[12'h500:12'hFFF]} |-> pslverr)
		else $error("unmapped access without pslverr");
	chk_mapped_ok: assert property (pready && paddr[13:2] inside {[12'h000:12'h012],
		[12'h400:12'h4FF]} |-> !pslverr)
		else $error("mapped access with pslverr");
	chk_ep_upper: assert property (pready && paddr[13:2] < 12'h010 |-> prdata[31:5] == 0)
		else $error("endpoint upper bits not zero");
	chk_frame_high: assert property (pready && paddr[13:2] == IDX_FRM_HIGH
		|-> prdata[31:3] == 0)
		else $error("frame high wider than three bits");
	chk_write_zero: assert property (pready && pwrite |-> prdata == 0)
		else $error("write returned data");
	chk_tok_done: assert property (token_valid |=> token_done)
		else $error("token not answered");
	chk_tok_quiet: assert property (!token_valid |=> !token_done)
		else $error("token answer without request");
	chk_accept_gate: assert property (token_accept |-> token_done)
		else $error("accept outside answer");
	chk_hshk_gate: assert property (token_handshake |-> token_accept)
		else $error("handshake without accept");
endmodule // usb_ep_ctrl_asserts
bind usb_ep_ctrl usb_ep_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .token_valid(token_valid), .token_done(token_done),
	.token_accept(token_accept), .token_handshake(token_handshake));

// ==== tb/usb_eng_model.sv ====
// Purpose: Engine-side partner: tokens, SOF, stalls, RAM port
// Assumes: Tasks are entered just after a rising edge
// Notes: Released data fields other than eng_ram_addr and token_kind go inverted so stale values never look valid
`timescale 1ns/1ps
module usb_eng_model
(
	input  wire logic                        pclk,
	output logic                             bus_reset_flag,
	output logic                             sof_valid,
	output logic [usb_ctl_pkg::FRAME_W-1:0] sof_frame,
	output logic                             stall_issued,
	output logic [3:0]                       stall_ep,
	output logic                             token_valid,
	output usb_ctl_pkg::token_kind_e         token_kind,
	output logic [6:0]                       token_addr,
	output logic [3:0]                       token_ep,
	output logic                             eng_ram_en,
	output logic                             eng_ram_we,
	output logic [7:0]                       eng_ram_addr,
	output logic [7:0]                       eng_ram_wdata
);
	import usb_ctl_pkg::*;
	initial
	begin
		{bus_reset_flag, sof_valid, stall_issued, token_valid, eng_ram_en, eng_ram_we} = '0;
		{sof_frame, stall_ep, token_addr, token_ep, eng_ram_addr, eng_ram_wdata} = '0;
		token_kind = TOK_OUT;
	end
	// ==========================================================
	// Strobe lasts one cycle, then an idle edge
	task automatic done_op();
		@(posedge pclk);
		{bus_reset_flag, sof_valid, stall_issued, token_valid, eng_ram_en, eng_ram_we} <= '0;
		{sof_frame, stall_ep, token_addr, token_ep, eng_ram_wdata} <=
			~{sof_frame, stall_ep, token_addr, token_ep, eng_ram_wdata};
		@(posedge pclk);
	endtask
	task automatic token(input token_kind_e k, input logic [6:0] a, input logic [3:0] e);
		token_valid <= 1'b1;
		token_kind <= k;
		token_addr <= a;
		token_ep <= e;
		done_op();
	endtask
	task automatic sof(input logic [FRAME_W-1:0] f);
		sof_valid <= 1'b1;
		sof_frame <= f;
		done_op();
	endtask
	task automatic stall(input logic [3:0] e);
		stall_issued <= 1'b1;
		stall_ep <= e;
		done_op();
	endtask
	task automatic bus_rst();
		bus_reset_flag <= 1'b1;
		done_op();
	endtask
	task automatic ram(input logic w, input logic [7:0] a, input logic [7:0] d);
		eng_ram_en <= 1'b1;
		eng_ram_we <= w;
		eng_ram_addr <= a;
		eng_ram_wdata <= d;
		done_op();
	endtask
endmodule // usb_eng_model

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the endpoint control slice
// Assumes: APB master here, engine partner in usb_eng_model
// Notes: APB, token and RAM results queue up; one watcher compares them; desc_live is checked inline
`timescale 1ns/1ps
module tb;
	import usb_ctl_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rd_pend = 0;
	logic [13:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, d;
	logic [3:0] pstrb = 4'hF, stall_ep, token_ep;
	logic pready, pslverr, token_done, token_accept, token_handshake, bus_reset_flag;
	logic sof_valid, stall_issued, token_valid, eng_ram_en, eng_ram_we;
	logic [10:0] sof_frame;
	logic [6:0] token_addr;
	logic [7:0] eng_ram_addr, eng_ram_wdata, eng_ram_rdata, a;
	logic [15:0] desc_live;
	token_kind_e token_kind;
	token_kind_e kinds[3] = '{TOK_OUT, TOK_IN, TOK_SETUP};
	int fails = 0, n_compared = 0, cyc = 0, seed = 39;
	logic [32:0] aq[$];
	logic [1:0] tq[$];
	logic [7:0] rq[$];
	always #2.5 pclk = ~pclk;
	usb_ep_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .bus_reset_flag, .sof_valid, .sof_frame, .stall_issued,
		.stall_ep, .token_valid, .token_kind, .token_addr, .token_ep, .token_done,
		.token_accept, .token_handshake, .desc_live, .eng_ram_en, .eng_ram_we,
		.eng_ram_addr, .eng_ram_wdata, .eng_ram_rdata);
	usb_eng_model u_eng (.pclk, .bus_reset_flag, .sof_valid, .sof_frame, .stall_issued,
		.stall_ep, .token_valid, .token_kind, .token_addr, .token_ep, .eng_ram_en,
		.eng_ram_we, .eng_ram_addr, .eng_ram_wdata);
	// ==========================================================
	// Tasks
	task automatic results();
		if (fails == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
		n_compared++;
		if (s !== e)
		begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [13:0] ad, input logic [31:0] wd,
		input logic [31:0] ed, input logic ee);
		aq.push_back({ee, ed});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~wd;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [13:0] ad, input logic [31:0] wd);
		apb(1'b1, ad, wd, 32'h0, 1'b0);
	endtask
	task automatic rd(input logic [13:0] ad, input logic [31:0] ed);
		apb(1'b0, ad, 32'h0, ed, 1'b0);
	endtask
	function automatic logic [1:0] tok_exp(input token_kind_e k, input logic [4:0] c);
		logic ok;
		ok = (k == TOK_OUT) ? c[2] : (k == TOK_IN) ? c[1] : (c[2] & c[1] & ~c[3]);
		return {ok, ok & c[4]};
	endfunction
	// ==========================================================
	// Watcher and hang limit
	always @(posedge pclk)
	begin
		if (psel && penable && pready === 1'b1)
			chk("apb", aq.pop_front(), {pslverr, prdata});
		if (token_done === 1'b1)
			chk("token", tq.pop_front(), {token_accept, token_handshake});
		if (rd_pend)
			chk("ram", rq.pop_front(), eng_ram_rdata);
		rd_pend <= eng_ram_en & ~eng_ram_we;
		if (++cyc == 20000)
		begin
			fails++;
			results();
		end
	end
	// ==========================================================
	// Scenarios
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 19; i++)
			rd(14'(i * 4), 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			d = $random(seed);
			wr(14'(i * 4), d);
			rd(14'(i * 4), {27'h0, d[4:0]});
			wr(14'(i * 4), 32'h0);
		end
		for (int b = 0; b < 4; b++)
			wr(14'h1000 + 14'((24 + b) * 4), 32'(8'hC0 + b));
		wr(14'h0C, 32'h2);
		repeat (2) @(posedge pclk);
		chk("desc_live", 33'h8, {17'h0, desc_live});
		rq.push_back(8'hC2);
		u_eng.ram(1'b0, 8'd26, 8'h00);
		wr(14'h40, 32'h2A);
		rd(14'h40, 32'h2A);
		for (int c = 0; c < 32; c += 2)
		begin
			wr(14'h14, 32'(c));
			for (int k = 0; k < 3; k++)
			begin
				tq.push_back(tok_exp(kinds[k], 5'(c)));
				u_eng.token(kinds[k], 7'h2A, 4'h5);
			end
		end
		tq.push_back(2'b00);
		u_eng.token(TOK_IN, 7'h2B, 4'h5);
		u_eng.bus_rst();
		rd(14'h40, 32'h0);
		tq.push_back(2'b11);
		u_eng.token(TOK_IN, 7'h00, 4'h5);
		u_eng.stall(4'h5);
		rd(14'h14, 32'h1F);
		rd(14'h18, 32'h0);
		u_eng.bus_rst();
		rd(14'h14, 32'h1F);
		pstrb <= 4'h0;
		wr(14'h14, 32'h0);
		pstrb <= 4'hF;
		rd(14'h14, 32'h1F);
		fork
			wr(14'h14, 32'h1E);
			begin
				repeat (2) @(posedge pclk);
				u_eng.stall(4'h5);
			end
		join
		rd(14'h14, 32'h1F);
		wr(14'h14, 32'h1E);
		rd(14'h14, 32'h1E);
		u_eng.sof(11'h5A3);
		rd(14'h44, 32'hA3);
		wr(14'h48, 32'h0);
		rd(14'h48, 32'h5);
		apb(1'b0, 14'h4C, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 14'h3000, 32'h5, 32'h0, 1'b1);
		for (int i = 0; i < 8; i++)
		begin
			d = $random(seed);
			a = (i == 7) ? 8'hFF : d[15:8];
			wr(14'h1000 + {a, 2'b00}, d);
			rq.push_back(d[7:0]);
			u_eng.ram(1'b0, a, 8'h00);
			u_eng.ram(1'b1, a, d[23:16]);
			rd(14'h1000 + {a, 2'b00}, {24'h0, d[23:16]});
		end
		repeat (4) @(posedge pclk);
		results();
	end
endmodule // tb
